//--- verilog/dpc_interp.sv
// packet command interpreter: receive, check, act, answer, report
`timescale 1ns/10ps
module dpc_interp
    import dpc_pkg::*;
#(
    parameter int FAN_CYC = FAN_PERIOD_CYC,
    parameter int TEMP_CYC = TEMP_PERIOD_CYC,
    // arbitrary neutral model and revision string
    parameter logic [127:0] VERSION_STR = 128'h44_45_56_3A_68_30_2E_30_2C_76_30_2E_30_20_20_20
)
(
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    output logic o_tx_valid,
    input wire logic i_tx_ready,
    output logic [7:0] o_tx_data,
    input wire logic [NUM_FANS-1:0] i_fan_en,
    input wire logic [NUM_SENSORS-1:0] i_temp_en,
    input wire logic [7:0] i_fan_cycles [NUM_FANS],
    input wire logic [15:0] i_fan_ticks [NUM_FANS],
    input wire logic [15:0] i_temp_value [NUM_SENSORS],
    input wire logic [127:0] i_nv_user,
    output logic o_nv_user_we,
    output logic [127:0] o_nv_user,
    output logic o_store_boot,
    output logic o_reboot,
    output logic o_host_reset,
    output logic o_host_power_off,
    output logic o_screen_we,
    output logic [CELL_W-1:0] o_screen_addr,
    output logic [7:0] o_screen_data,
    output logic o_cursor_home
);
    ////////////////////////////////////////////////////////////////////////////
    // receive side
    dpc_rx_t rx_st;
    logic [5:0] rx_code;
    logic [1:0] rx_cls;
    logic [4:0] rx_len;
    logic [4:0] rx_cnt;
    logic [7:0] rx_buf [MAX_LEN];
    logic [15:0] rx_crc;
    logic [7:0] rx_crcl;
    logic cmd_go;
    logic [10:0] idle_cnt;

    // a stalled partial packet is dropped so the parser resyncs on the next one
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            idle_cnt <= 11'h0;
        else if (i_rx_valid || rx_st == RX_TYPE)
            idle_cnt <= 11'h0;
        else if (idle_cnt != 11'(IDLE_RESYNC_CYC))
            idle_cnt <= idle_cnt + 11'h1;
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rx_st <= RX_TYPE;
            rx_code <= 6'h0;
            rx_cls <= 2'h0;
            rx_len <= 5'h0;
            rx_cnt <= 5'h0;
            rx_crc <= CRC_INIT;
            rx_crcl <= 8'h0;
            cmd_go <= 1'b0;
        end
        else
        begin
            cmd_go <= 1'b0;
            if (idle_cnt == 11'(IDLE_RESYNC_CYC))
                rx_st <= RX_TYPE;
            else if (i_rx_valid)
            begin
                unique case (rx_st)
                    RX_TYPE:
                    begin
                        {rx_cls, rx_code} <= i_rx_data;
                        rx_crc <= crc_byte(CRC_INIT, i_rx_data);
                        rx_st <= RX_LEN;
                    end
                    RX_LEN:
                    begin
                        rx_len <= i_rx_data[4:0];
                        rx_cnt <= 5'h0;
                        rx_crc <= crc_byte(rx_crc, i_rx_data);
                        if (i_rx_data > {3'h0, MAX_LEN})
                            rx_st <= RX_TYPE;
                        else if (i_rx_data == 8'h00)
                            rx_st <= RX_CRCL;
                        else
                            rx_st <= RX_DATA;
                    end
                    RX_DATA:
                    begin
                        rx_crc <= crc_byte(rx_crc, i_rx_data);
                        rx_cnt <= rx_cnt + 5'h1;
                        if (rx_cnt == rx_len - 5'h1)
                            rx_st <= RX_CRCL;
                    end
                    RX_CRCL:
                    begin
                        rx_crcl <= i_rx_data;
                        rx_st <= RX_CRCH;
                    end
                    RX_CRCH:
                    begin
                        // crc failures and non-command classes are silently dropped
                        if ({i_rx_data, rx_crcl} == ~rx_crc && rx_cls == CLS_CMD)
                            cmd_go <= 1'b1;
                        rx_st <= RX_TYPE;
                    end
                    default:
                        rx_st <= RX_TYPE;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rx_valid && rx_st == RX_DATA)
            rx_buf[rx_cnt] <= i_rx_data;
    end

    ////////////////////////////////////////////////////////////////////////////
    // command decode and actions
    function automatic logic args_are(input logic [7:0] a, input logic [7:0] b,
                                      input logic [7:0] c);
        return rx_len == BOOT_LEN && rx_buf[0] == a && rx_buf[1] == b && rx_buf[2] == c;
    endfunction : args_are

    logic cmd_ok;
    logic is_reboot;
    logic is_hreset;
    logic is_hoff;

    always_comb
    begin
        is_reboot = args_are(8'h08, 8'h12, 8'h63);
        is_hreset = args_are(8'h0C, 8'h1C, 8'h61);
        is_hoff = args_are(8'h03, 8'h0B, 8'h5F);
        unique case (rx_code)
            OP_PING: cmd_ok = (rx_len <= PING_MAX);
            OP_VER: cmd_ok = (rx_len == 5'h0);
            OP_UWR: cmd_ok = (rx_len == USER_LEN);
            OP_URD: cmd_ok = (rx_len == 5'h0);
            OP_STORE: cmd_ok = (rx_len == 5'h0);
            OP_BOOT: cmd_ok = is_reboot || is_hreset || is_hoff;
            OP_CLR: cmd_ok = (rx_len == 5'h0);
            default: cmd_ok = 1'b0;
        endcase
    end

    logic act;
    assign act = cmd_go && cmd_ok;

    logic clr_busy;
    logic [CELL_W-1:0] clr_addr;

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_nv_user_we <= 1'b0;
            o_nv_user <= 128'h0;
            o_store_boot <= 1'b0;
            o_reboot <= 1'b0;
            o_host_reset <= 1'b0;
            o_host_power_off <= 1'b0;
        end
        else
        begin
            o_nv_user_we <= act && rx_code == OP_UWR;
            o_store_boot <= act && rx_code == OP_STORE;
            o_reboot <= act && rx_code == OP_BOOT && is_reboot;
            o_host_reset <= act && rx_code == OP_BOOT && is_hreset;
            o_host_power_off <= act && rx_code == OP_BOOT && is_hoff;
            if (act && rx_code == OP_UWR)
            begin
                for (int i = 0; i < 16; i++)
                    o_nv_user[127 - 8 * i -: 8] <= rx_buf[i];
            end
        end
    end

    // clearing walks one cell per cycle; screen outputs registered
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            clr_busy <= 1'b0;
            clr_addr <= '0;
            o_screen_we <= 1'b0;
            o_screen_addr <= '0;
            o_screen_data <= BLANK_CHAR;
            o_cursor_home <= 1'b0;
        end
        else
        begin
            o_screen_we <= clr_busy;
            o_screen_addr <= clr_addr;
            o_screen_data <= BLANK_CHAR;
            o_cursor_home <= act && rx_code == OP_CLR;
            if (act && rx_code == OP_CLR)
            begin
                clr_busy <= 1'b1;
                clr_addr <= '0;
            end
            else if (clr_busy)
            begin
                clr_addr <= clr_addr + 1'b1;
                if (clr_addr == CELL_W'(SCREEN_CELLS - 1))
                    clr_busy <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // answer and report transmit
    logic [NUM_FANS-1:0] fan_pend;
    logic [NUM_SENSORS-1:0] temp_pend;
    logic ack_fan;
    logic ack_temp;

    dpc_report_timer #(
        .FAN_CYC(FAN_CYC),
        .TEMP_CYC(TEMP_CYC)
    ) u_rpt (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_fan_en(i_fan_en),
        .i_temp_en(i_temp_en),
        .i_ack_fan(ack_fan),
        .i_ack_temp(ack_temp),
        .o_fan_pend(fan_pend),
        .o_temp_pend(temp_pend)
    );

    dpc_tx_t tx_st;
    logic [7:0] tx_type;
    logic [4:0] tx_len;
    logic [4:0] tx_cnt;
    logic [7:0] tx_buf [MAX_LEN];
    logic [15:0] tx_crc;
    logic ans_pend;
    logic [7:0] fb_data;
    logic fb_valid;
    logic fb_ready;
    logic [1:0] fan_sel;
    logic [4:0] temp_sel;

    always_comb
    begin
        fan_sel = 2'h0;
        for (int i = NUM_FANS - 1; i >= 0; i--)
            if (fan_pend[i])
                fan_sel = 2'(i);
        temp_sel = 5'h0;
        for (int j = NUM_SENSORS - 1; j >= 0; j--)
            if (temp_pend[j])
                temp_sel = 5'(j);
    end

    // answers go ahead of pending reports when the transmitter is idle, keeping the reply latency short
    logic start_ans;
    logic start_fan;
    logic start_temp;
    assign start_ans = tx_st == TX_IDLE && ans_pend;
    assign start_fan = tx_st == TX_IDLE && !ans_pend && |fan_pend;
    assign start_temp = tx_st == TX_IDLE && !ans_pend && !(|fan_pend) && |temp_pend;
    assign ack_fan = start_fan;
    assign ack_temp = start_temp;

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            ans_pend <= 1'b0;
        else if (cmd_go)
            ans_pend <= 1'b1;
        else if (start_ans)
            ans_pend <= 1'b0;
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            tx_st <= TX_IDLE;
            tx_type <= 8'h0;
            tx_len <= 5'h0;
            tx_cnt <= 5'h0;
            tx_crc <= CRC_INIT;
        end
        else if (tx_st == TX_IDLE)
        begin
            tx_cnt <= 5'h0;
            tx_crc <= CRC_INIT;
            if (start_ans)
            begin
                tx_st <= TX_TYPE;
                tx_type <= {cmd_ok ? CLS_RSP : CLS_ERR, rx_code};
                unique case (rx_code)
                    OP_PING: tx_len <= rx_len;
                    OP_VER: tx_len <= VER_LEN;
                    OP_URD: tx_len <= USER_LEN;
                    default: tx_len <= 5'h0;
                endcase
                if (!cmd_ok)
                    tx_len <= 5'h0;
            end
            else if (start_fan)
            begin
                tx_st <= TX_TYPE;
                tx_type <= {CLS_RPT, RPT_FAN};
                tx_len <= FAN_RPT_LEN;
            end
            else if (start_temp)
            begin
                tx_st <= TX_TYPE;
                tx_type <= {CLS_RPT, RPT_TEMP};
                tx_len <= TEMP_RPT_LEN;
            end
        end
        else if (fb_ready)
        begin
            unique case (tx_st)
                TX_TYPE:
                begin
                    tx_crc <= crc_byte(tx_crc, tx_type);
                    tx_st <= TX_LEN;
                end
                TX_LEN:
                begin
                    tx_crc <= crc_byte(tx_crc, {3'h0, tx_len});
                    tx_st <= (tx_len == 5'h0) ? TX_CRCL : TX_DATA;
                end
                TX_DATA:
                begin
                    tx_crc <= crc_byte(tx_crc, tx_buf[tx_cnt]);
                    tx_cnt <= tx_cnt + 5'h1;
                    if (tx_cnt == tx_len - 5'h1)
                        tx_st <= TX_CRCL;
                end
                TX_CRCL:
                    tx_st <= TX_CRCH;
                TX_CRCH:
                    tx_st <= TX_IDLE;
                default:
                    tx_st <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (start_ans)
        begin
            for (int i = 0; i < 16; i++)
            begin
                unique case (rx_code)
                    OP_VER: tx_buf[i] <= VERSION_STR[127 - 8 * i -: 8];
                    OP_URD: tx_buf[i] <= i_nv_user[127 - 8 * i -: 8];
                    default: tx_buf[i] <= rx_buf[i];
                endcase
            end
        end
        else if (start_fan)
        begin
            tx_buf[0] <= {6'h0, fan_sel};
            tx_buf[1] <= i_fan_cycles[fan_sel];
            tx_buf[2] <= i_fan_ticks[fan_sel][7:0];
            tx_buf[3] <= i_fan_ticks[fan_sel][15:8];
        end
        else if (start_temp)
        begin
            tx_buf[0] <= {3'h0, temp_sel};
            tx_buf[1] <= i_temp_value[temp_sel][7:0];
            tx_buf[2] <= i_temp_value[temp_sel][15:8];
            tx_buf[3] <= 8'h00;
        end
    end

    always_comb
    begin
        fb_valid = 1'b1;
        unique case (tx_st)
            TX_TYPE: fb_data = tx_type;
            TX_LEN: fb_data = {3'h0, tx_len};
            TX_DATA: fb_data = tx_buf[tx_cnt];
            TX_CRCL: fb_data = ~tx_crc[7:0];
            TX_CRCH: fb_data = ~tx_crc[15:8];
            default:
            begin
                fb_data = 8'h00;
                fb_valid = 1'b0;
            end
        endcase
    end

    dpc_buf2 #(
        .WIDTH(8)
    ) u_buf (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_valid(fb_valid),
        .o_ready(fb_ready),
        .i_data(fb_data),
        .o_valid(o_tx_valid),
        .i_ready(i_tx_ready),
        .o_data(o_tx_data)
    );
endmodule : dpc_interp

//--- verilog/dpc_pkg.sv
// constants and types shared by the display packet command block
// What this block does
// - every command with length 0-22 and a good crc gets exactly one answer packet
// - answer keeps the command's low six bits
// - fan reports every half second when enabled
// - temperature reports each second, 32 sensors
// - ping echoes up to 16 bytes
// - version query returns 16 byte string
// - user area write takes 16 bytes
// - user area read returns 16 bytes
// - store boot state saves display settings
// - reporting enables never saved in boot state
// - reboot only on bytes 8 18 99
// - host reset on bytes 12 28 97
// - host power off on bytes 3 11 95
// - command five actions answer 0x45 empty
// - clear screen fills 0x20, cursor home
// - type byte holds class and code
// - packet is type, length 0-22, data
// - 16-bit crc appended, low byte first
// - answer within 250 ms
package dpc_pkg;
    localparam logic [1:0] CLS_CMD = 2'h0;
    localparam logic [1:0] CLS_RSP = 2'h1;
    localparam logic [1:0] CLS_RPT = 2'h2;
    localparam logic [1:0] CLS_ERR = 2'h3;
    localparam logic [5:0] OP_PING = 6'h00;
    localparam logic [5:0] OP_VER = 6'h01;
    localparam logic [5:0] OP_UWR = 6'h02;
    localparam logic [5:0] OP_URD = 6'h03;
    localparam logic [5:0] OP_STORE = 6'h04;
    localparam logic [5:0] OP_BOOT = 6'h05;
    localparam logic [5:0] OP_CLR = 6'h06;
    localparam logic [5:0] RPT_FAN = 6'h01;
    localparam logic [5:0] RPT_TEMP = 6'h02;
    localparam logic [4:0] MAX_LEN = 5'h16;
    localparam logic [4:0] PING_MAX = 5'h10;
    localparam logic [4:0] USER_LEN = 5'h10;
    localparam logic [4:0] VER_LEN = 5'h10;
    localparam logic [4:0] BOOT_LEN = 5'h03;
    localparam logic [4:0] FAN_RPT_LEN = 5'h04;
    localparam logic [4:0] TEMP_RPT_LEN = 5'h04;
    localparam logic [7:0] BLANK_CHAR = 8'h20;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY_REV = 16'h8408;
    localparam int CLK_HZ = 20000000;
    localparam int FAN_PERIOD_MS = 500;
    localparam int TEMP_PERIOD_MS = 1000;
    localparam int ANSWER_MS = 250;
    localparam int FAN_PERIOD_CYC = CLK_HZ / 1000 * FAN_PERIOD_MS;
    localparam int TEMP_PERIOD_CYC = CLK_HZ / 1000 * TEMP_PERIOD_MS;
    localparam int ANSWER_CYC = CLK_HZ / 1000 * ANSWER_MS;
    localparam int NUM_FANS = 4;
    localparam int NUM_SENSORS = 32;
    localparam int SCREEN_CELLS = 80;
    localparam int CELL_W = 7;
    localparam int IDLE_RESYNC_CYC = 2000;

    typedef enum logic [2:0]
    {
        RX_TYPE = 3'h0,
        RX_LEN = 3'h1,
        RX_DATA = 3'h2,
        RX_CRCL = 3'h3,
        RX_CRCH = 3'h4
    } dpc_rx_t;

    typedef enum logic [2:0]
    {
        TX_IDLE = 3'h0,
        TX_TYPE = 3'h1,
        TX_LEN = 3'h2,
        TX_DATA = 3'h3,
        TX_CRCL = 3'h4,
        TX_CRCH = 3'h5
    } dpc_tx_t;

    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] d);
        logic [15:0] c;
        c = crc ^ {8'h00, d};
        for (int i = 0; i < 8; i++)
        begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY_REV) : (c >> 1);
        end
        return c;
    endfunction : crc_byte
endpackage : dpc_pkg

//--- verilog/dpc_buf2.sv
// two-entry valid/ready buffer for the outgoing byte stream
`timescale 1ns/10ps
module dpc_buf2
    import dpc_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    logic [WIDTH-1:0] mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic push;
    logic pop;

    assign o_ready = (count != 2'h2);
    assign o_valid = (count != 2'h0);
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    assign o_data = mem[rd_ptr];

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
            mem[0] <= '0;
            mem[1] <= '0;
        end
        else
        begin
            if (push)
            begin
                mem[wr_ptr] <= i_data;
                wr_ptr <= ~wr_ptr;
            end
            if (pop)
            begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : dpc_buf2

//--- verilog/dpc_report_timer.sv
// periodic fan and temperature report scheduler
`timescale 1ns/10ps
module dpc_report_timer
    import dpc_pkg::*;
#(
    parameter int FAN_CYC = FAN_PERIOD_CYC,
    parameter int TEMP_CYC = TEMP_PERIOD_CYC
)
(
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic [NUM_FANS-1:0] i_fan_en,
    input wire logic [NUM_SENSORS-1:0] i_temp_en,
    input wire logic i_ack_fan,
    input wire logic i_ack_temp,
    output logic [NUM_FANS-1:0] o_fan_pend,
    output logic [NUM_SENSORS-1:0] o_temp_pend
);
    logic [31:0] fan_cnt;
    logic [31:0] temp_cnt;
    logic fan_tick;
    logic temp_tick;
    logic [1:0] fan_idx;
    logic [4:0] temp_idx;

    assign fan_tick = (fan_cnt == 32'(FAN_CYC - 1));
    assign temp_tick = (temp_cnt == 32'(TEMP_CYC - 1));

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            fan_cnt <= 32'h0;
            temp_cnt <= 32'h0;
        end
        else
        begin
            fan_cnt <= fan_tick ? 32'h0 : fan_cnt + 32'h1;
            temp_cnt <= temp_tick ? 32'h0 : temp_cnt + 32'h1;
        end
    end

    // a new period's set wins over a same-cycle acknowledge
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_fan_pend <= '0;
            o_temp_pend <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_FANS; i++)
            begin
                if (fan_tick && i_fan_en[i])
                    o_fan_pend[i] <= 1'b1;
                else if (i_ack_fan && (fan_idx == 2'(i)))
                    o_fan_pend[i] <= 1'b0;
                else if (!i_fan_en[i])
                    o_fan_pend[i] <= 1'b0;
            end
            for (int j = 0; j < NUM_SENSORS; j++)
            begin
                if (temp_tick && i_temp_en[j])
                    o_temp_pend[j] <= 1'b1;
                else if (i_ack_temp && (temp_idx == 5'(j)))
                    o_temp_pend[j] <= 1'b0;
                else if (!i_temp_en[j])
                    o_temp_pend[j] <= 1'b0;
            end
        end
    end

    always_comb
    begin
        fan_idx = 2'h0;
        for (int i = NUM_FANS - 1; i >= 0; i--)
        begin
            if (o_fan_pend[i])
                fan_idx = 2'(i);
        end
        temp_idx = 5'h0;
        for (int j = NUM_SENSORS - 1; j >= 0; j--)
        begin
            if (o_temp_pend[j])
                temp_idx = 5'(j);
        end
    end
endmodule : dpc_report_timer

//--- testbench/dpc_interp_props.sv
// port assertions for the packet command interpreter
`timescale 1ns/10ps
module dpc_interp_props
    import dpc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_rx_valid,
    input wire logic i_tx_ready,
    input wire logic o_tx_valid,
    input wire logic [7:0] o_tx_data,
    input wire logic o_nv_user_we,
    input wire logic o_store_boot,
    input wire logic o_reboot,
    input wire logic o_host_reset,
    input wire logic o_host_power_off,
    input wire logic o_screen_we,
    input wire logic [CELL_W-1:0] o_screen_addr,
    input wire logic [7:0] o_screen_data,
    input wire logic o_cursor_home
);
    logic [5:0] act;
    assign act = {o_nv_user_we, o_store_boot, o_reboot, o_host_reset, o_host_power_off,
        o_cursor_home};
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_arst_n);
    ////////////////////////////////////////////////////////////////////////////////
    tx_hold_a: assert property (
        o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data)) else $error("tx moved");
    scr_blank_a: assert property (o_screen_data == 8'h20) else $error("bad fill");
    scr_first_a: assert property (
        $rose(o_screen_we) |-> o_screen_addr == 7'h00) else $error("clear start");
    scr_step_a: assert property (
        o_screen_we && $past(o_screen_we) |-> o_screen_addr == $past(o_screen_addr) + 7'h01)
        else $error("clear step");
    scr_last_a: assert property (
        $fell(o_screen_we) |-> $past(o_screen_addr) == 7'h4F) else $error("clear end");
    act_pulse_a: assert property (act != 6'h00 |=> act == 6'h00) else $error("long act");
    act_single_a: assert property ($onehot0(act)) else $error("two acts");
    act_cause_a: assert property (
        act != 6'h00 |-> $past(i_rx_valid, 2)) else $error("act uncaused");
endmodule : dpc_interp_props

//--- testbench/dpc_host_model.sv
// host side sink for answer and report bytes
`timescale 1ns/10ps
module dpc_host_model
(
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_stall,
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    output logic o_tx_ready
);
    logic [7:0] rxq[$];
    logic [2:0] cnt;
    // takes one byte in eight while stalling, so the buffer fills
    assign o_tx_ready = !i_stall || cnt == 3'h7;
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            cnt <= 3'h0;
        else
            cnt <= cnt + 3'h1;
    end
    always @(posedge i_clk_sys)
    begin
        if (i_arst_n && i_tx_valid && o_tx_ready)
            rxq.push_back(i_tx_data);
    end
endmodule : dpc_host_model

//--- testbench/tb_dpc_interp.sv
// self-checking bench for the packet command interpreter
`timescale 1ns/10ps
module tb_dpc_interp;
    import dpc_pkg::*;
    logic i_clk_sys = 1'b0, i_arst_n = 1'b1, i_rx_valid = 1'b0, stall = 1'b0;
    logic i_tx_ready, o_tx_valid, o_nv_user_we, o_store_boot, o_reboot, o_host_reset;
    logic o_host_power_off, o_screen_we, o_cursor_home;
    logic [7:0] i_rx_data = 8'h00, o_tx_data, o_screen_data, pk[$], b[$];
    logic [NUM_FANS-1:0] i_fan_en = 4'h0;
    logic [NUM_SENSORS-1:0] i_temp_en = 32'h0;
    logic [7:0] i_fan_cycles[NUM_FANS] = '{8'h10, 8'h20, 8'h30, 8'h40};
    logic [15:0] i_fan_ticks[NUM_FANS] = '{default: 16'h1234};
    logic [15:0] i_temp_value[NUM_SENSORS] = '{default: 16'h0ABC};
    logic [127:0] i_nv_user = 128'h000102030405060708090A0B0C0D0E0F, o_nv_user;
    logic [CELL_W-1:0] o_screen_addr;
    logic [5:0] seen = 6'h00;
    logic [63:0] r;
    int fails = 0, n_tests = 0, cyc = 0;
    // code, length, three data bytes, answer type, answer length, expected actions
    logic [63:0] rows[12] = '{64'h0000000000400000, 64'h0010000102401000,
        64'h0011000000C00000, 64'h0100000000411000, 64'h0210000102420020,
        64'h020F000000C20000, 64'h0300000102431000, 64'h0400000000440010,
        64'h0503081263450008, 64'h05030C1C61450004, 64'h0503030B5F450002,
        64'h0503081262C50000};
    always #25 i_clk_sys = ~i_clk_sys;
    dpc_host_model i_dpc_host_model (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
        .i_stall(stall), .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready));
    dpc_interp #(.FAN_CYC(200), .TEMP_CYC(400)) i_dpc_interp (.*);
    always @(posedge i_clk_sys)
    begin
        seen = seen | {o_nv_user_we, o_store_boot, o_reboot, o_host_reset, o_host_power_off,
            o_cursor_home};
        cyc++;
        if (cyc == 40000)
        begin
            fails++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] crc(logic [15:0] c, logic [7:0] d);
        c = c ^ {8'h00, d};
        repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
        return c;
    endfunction : crc
    function automatic logic [7:0] gen(logic [63:0] v, int k);
        return k < 3 ? v[47 - 8 * k -: 8] : 8'(k);
    endfunction : gen
    task automatic check(logic [15:0] got, logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic send(logic bad);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (b[k]) c = crc(c, b[k]);
        c = ~c ^ {15'h0, bad};
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        foreach (b[k])
        begin
            @(posedge i_clk_sys);
            i_rx_valid <= 1'b1;
            i_rx_data <= b[k];
        end
        @(posedge i_clk_sys) i_rx_valid <= 1'b0;
    endtask : send
    task automatic get_pkt();
        int w;
        logic [15:0] c;
        w = 0;
        c = 16'hFFFF;
        while (!(i_dpc_host_model.rxq.size() > 1 &&
            i_dpc_host_model.rxq.size() >= i_dpc_host_model.rxq[1] + 4) && w < 3000)
        begin
            @(posedge i_clk_sys);
            w++;
        end
        pk = i_dpc_host_model.rxq;
        i_dpc_host_model.rxq.delete();
        check(w < 3000, 1'b1);
        if (w < 3000)
        begin
            for (int k = 0; k < pk[1] + 2; k++) c = crc(c, pk[k]);
            check({pk[pk[1] + 3], pk[pk[1] + 2]}, ~c);
        end
    endtask : get_pkt
    task automatic complete_run();
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        i_arst_n <= 1'b0;
        repeat (6) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        @(negedge i_clk_sys);
        check({o_tx_valid, seen, o_screen_data}, 16'h0020);
        foreach (rows[i])
        begin
            r = rows[i];
            b = {r[63:56], r[55:48]};
            for (int k = 0; k < r[55:48]; k++) b.push_back(gen(r, k));
            stall <= i[0];
            seen = 6'h00;
            send(1'b0);
            get_pkt();
            check(pk[0], r[23:16]);
            check(pk[1], r[15:8]);
            if (r[23:16] == 8'h40 || r[23:16] == 8'h43)
                for (int k = 0; k < r[15:8]; k++) check(pk[k + 2], gen(r, k));
            repeat (20) @(posedge i_clk_sys);
            check(seen, r[5:0]);
            $display("row %0d done", i);
        end
        check(o_nv_user[15:0], 16'h0E0F);
        b = {8'h06, 8'h00};
        send(1'b0);
        get_pkt();
        check({pk[0], pk[1]}, 16'h4600);
        repeat (100) @(posedge i_clk_sys);
        check(seen, 6'h01);
        b = {8'h00, 8'h00};
        send(1'b1);
        repeat (500) @(posedge i_clk_sys);
        check(i_dpc_host_model.rxq.size(), 0);
        i_fan_en <= 4'h2;
        get_pkt();
        i_fan_en <= 4'h0;
        check({pk[0], pk[1], pk[2], pk[3]}, 32'h81040120);
        check({pk[5], pk[4]}, 16'h1234);
        repeat (600) @(posedge i_clk_sys);
        i_dpc_host_model.rxq.delete();
        i_temp_en <= 32'h80000000;
        get_pkt();
        check({pk[0], pk[1], pk[2]}, 24'h82041F);
        check({pk[4], pk[3]}, 16'h0ABC);
        $display("special cases done");
        complete_run();
    end
endmodule : tb_dpc_interp
bind dpc_interp dpc_interp_props i_dpc_interp_props (.*);
